/* File: core/bst_pkg.sv */
package bst_pkg;

    // ************************************************************
    // instruction register
    // ************************************************************
    localparam int          IR_W          = 3;
    localparam logic [2:0]  INS_EXTEST    = 3'h0;
    localparam logic [2:0]  INS_IDCODE    = 3'h1;
    localparam logic [2:0]  INS_SAMPLEZ   = 3'h2;
    localparam logic [2:0]  INS_RSV_3     = 3'h3;
    localparam logic [2:0]  INS_SAMPLE    = 3'h4;
    localparam logic [2:0]  INS_RSV_5     = 3'h5;
    localparam logic [2:0]  INS_RSV_6     = 3'h6;
    localparam logic [2:0]  INS_BYPASS    = 3'h7;
    localparam logic [2:0]  IR_CAPTURE    = 3'h1;
    localparam logic [2:0]  IR_RESET      = INS_IDCODE;

    // ************************************************************
    // data registers
    // ************************************************************
    localparam int          ID_W          = 32;
    // arbitrary identification value; bit 0 flags an id register
    localparam logic [31:0] IDCODE_VAL    = 32'h0A5C_3E01;
    localparam int          BSR_LEN       = 109;
    localparam int          TRI_CELL      = 108;
    localparam int          Q_CELL_LSB    = 0;
    localparam int          Q_W           = 36;
    localparam logic        BYP_CAPTURE   = 1'b0;
    localparam logic        TRI_RESET     = 1'b1;

    // ************************************************************
    // controller states, gray steps along the usual path
    // ************************************************************
    typedef enum logic [3:0] {
        ST_TLR    = 4'h0,
        ST_RTI    = 4'h1,
        ST_SEL_DR = 4'h3,
        ST_CAP_DR = 4'h2,
        ST_SH_DR  = 4'h6,
        ST_EX1_DR = 4'h7,
        ST_PA_DR  = 4'h5,
        ST_EX2_DR = 4'h4,
        ST_UPD_DR = 4'hC,
        ST_SEL_IR = 4'hD,
        ST_CAP_IR = 4'hF,
        ST_SH_IR  = 4'hE,
        ST_EX1_IR = 4'hA,
        ST_PA_IR  = 4'hB,
        ST_EX2_IR = 4'h9,
        ST_UPD_IR = 4'h8
    } bst_state_e;

endpackage

/* File: core/bst_sync.sv */
`timescale 1ns/1ps
module bst_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // level in, level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    // first stage is read only by the second
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

/* File: core/bst_tap_fsm.sv */
`timescale 1ns/1ps
module bst_tap_fsm (
    // test clock and port reset
    input  wire logic           tck,
    input  wire logic           trst_n,
    // mode select
    input  wire logic           tms,
    // state
    output bst_pkg::bst_state_e state
);
    bst_pkg::bst_state_e st_q;
    bst_pkg::bst_state_e st_d;

    assign state = st_q;

    // advance on every rising test clock edge by tms
    always_comb begin
        case (st_q)
            bst_pkg::ST_TLR:
                st_d = tms ? bst_pkg::ST_TLR : bst_pkg::ST_RTI;
            bst_pkg::ST_RTI:
                st_d = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
            bst_pkg::ST_SEL_DR:
                st_d = tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
            bst_pkg::ST_CAP_DR:
                st_d = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_SH_DR:
                st_d = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_EX1_DR:
                st_d = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PA_DR;
            bst_pkg::ST_PA_DR:
                st_d = tms ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PA_DR;
            bst_pkg::ST_EX2_DR:
                st_d = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
            bst_pkg::ST_UPD_DR:
                st_d = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
            bst_pkg::ST_SEL_IR:
                st_d = tms ? bst_pkg::ST_TLR : bst_pkg::ST_CAP_IR;
            bst_pkg::ST_CAP_IR:
                st_d = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_SH_IR:
                st_d = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_EX1_IR:
                st_d = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PA_IR;
            bst_pkg::ST_PA_IR:
                st_d = tms ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PA_IR;
            bst_pkg::ST_EX2_IR:
                st_d = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
            bst_pkg::ST_UPD_IR:
                st_d = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
            default:
                st_d = bst_pkg::ST_TLR;
        endcase
    end

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            st_q <= bst_pkg::ST_TLR;
        end else begin
            st_q <= st_d; // [R16]
        end
    end
endmodule

/* File: core/bst_top.sv */
`timescale 1ns/1ps
// Summary of operation
// [R1] three-bit instruction, eight codes, three reserved
// [R2] instruction shifts in Shift-IR, applies at Update-IR
// [R3] IDCODE captures and shifts 32-bit identity
// [R4] IDCODE current after power-up and Test-Logic-Reset
// [R5] SAMPLE Z selects scan chain, floats output bus
// [R6] SAMPLE/PRELOAD capture loads all pin levels
// [R7] controller ignores sampled memory clock levels
// [R8] captured scan chain shifts out in Shift-DR
// [R9] shifted pattern moves to preload latches
// [R10] preload shifts in while samples shift out
// [R11] BYPASS puts one-bit register in path
// [R12] EXTEST drives preload values onto outputs
// [R13] cell 108 gates read-data output drivers
// [R14] Update-DR copies tri-state cell into latch
// [R15] tri-state latch high at power-up, reset
// [R16] state advances on rising clock by mode select
// [R17] encodings 000,001,010,100,111; others reserved
// [R18] Capture-IR loads low two bits with 01
// [R19] five mode-select highs reset the port
// [R20] sample inputs rising, change data out falling
// [R21] data out driven only in shift states
module bst_top #(
    parameter int BSR_N  = bst_pkg::BSR_LEN,
    parameter int QW     = bst_pkg::Q_W,
    parameter int Q_LSB  = bst_pkg::Q_CELL_LSB
) (
    // system clock and power-up reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // test access port
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    output logic                  tdo,
    output logic                  tdo_oe,
    // present pin levels seen by the scan cells
    input  wire logic [BSR_N-1:0] bsr_pin_lvl,
    // read data from the memory core
    input  wire logic [QW-1:0]    core_q,
    input  wire logic             core_q_oe,
    // read data output pads
    output logic      [QW-1:0]    pad_q,
    output logic                  pad_q_oe
);

    // ************************************************************
    // test clock domain reset
    // ************************************************************
    logic trst_n;

    // released two test clock edges after power-up reset
    bst_sync #(
        .W      (1)
    ) u_trst_sync (
        .clk    (tck),
        .rst_n  (rst_n),
        .d      (1'b1),
        .q      (trst_n)
    );

    // ************************************************************
    // controller
    // ************************************************************
    bst_pkg::bst_state_e state;

    bst_tap_fsm u_fsm (
        .tck    (tck),
        .trst_n (trst_n),
        .tms    (tms),
        .state  (state)
    );

    wire st_tlr    = (state == bst_pkg::ST_TLR);
    wire st_cap_ir = (state == bst_pkg::ST_CAP_IR);
    wire st_sh_ir  = (state == bst_pkg::ST_SH_IR);
    wire st_upd_ir = (state == bst_pkg::ST_UPD_IR);
    wire st_cap_dr = (state == bst_pkg::ST_CAP_DR);
    wire st_sh_dr  = (state == bst_pkg::ST_SH_DR);
    wire st_upd_dr = (state == bst_pkg::ST_UPD_DR);

    // ************************************************************
    // instruction register
    // ************************************************************
    logic [2:0] ir_sh_q;
    logic [2:0] ir_q;

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            ir_sh_q <= bst_pkg::IR_CAPTURE;
        end else if (st_cap_ir) begin
            ir_sh_q <= bst_pkg::IR_CAPTURE; // [R18]
        end else if (st_sh_ir) begin
            ir_sh_q <= {tdi, ir_sh_q[2:1]}; // [R2] [R20]
        end
    end

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            ir_q <= bst_pkg::IR_RESET;
        end else if (st_tlr) begin
            ir_q <= bst_pkg::IR_RESET; // [R4]
        end else if (st_upd_ir) begin
            ir_q <= ir_sh_q; // [R2]
        end
    end

    // reserved codes fall back to the bypass path
    wire ins_extest = (ir_q == bst_pkg::INS_EXTEST); // [R17]
    wire ins_idcode = (ir_q == bst_pkg::INS_IDCODE);
    wire ins_floatz = (ir_q == bst_pkg::INS_SAMPLEZ);
    wire ins_sample = (ir_q == bst_pkg::INS_SAMPLE);
    wire sel_bsr    = ins_extest | ins_floatz | ins_sample; // [R1]
    wire sel_id     = ins_idcode;
    wire sel_byp    = !sel_bsr && !sel_id; // [R1] [R11]

    // ************************************************************
    // pin level capture
    // ************************************************************
    logic [BSR_N-1:0] pin_s;

    // pins change on the memory clock, far faster than the test clock
    bst_sync #(
        .W      (BSR_N)
    ) u_pin_sync (
        .clk    (tck),
        .rst_n  (trst_n),
        .d      (bsr_pin_lvl),
        .q      (pin_s)
    );

    // ************************************************************
    // data registers
    // ************************************************************
    logic [BSR_N-1:0] bsr_sh_q;
    logic [BSR_N-1:0] preload_q;
    logic [31:0]      id_sh_q;
    logic             byp_q;
    logic             upd_tgl_q;

    localparam logic [BSR_N-1:0] PRELOAD_RST =
        {{(BSR_N-1){1'b0}}, bst_pkg::TRI_RESET} << bst_pkg::TRI_CELL;

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            bsr_sh_q <= '0;
        end else if (st_cap_dr && sel_bsr) begin
            bsr_sh_q <= pin_s; // [R6]
        end else if (st_sh_dr && sel_bsr) begin
            bsr_sh_q <= {tdi, bsr_sh_q[BSR_N-1:1]}; // [R8] [R10] [R12]
        end
    end

    wire pre_load = st_upd_dr && (ins_sample || ins_extest);

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            preload_q <= PRELOAD_RST; // [R15]
        end else if (st_tlr) begin
            preload_q[bst_pkg::TRI_CELL] <= bst_pkg::TRI_RESET; // [R15]
        end else if (pre_load) begin
            preload_q <= bsr_sh_q; // [R9] [R14]
        end
    end

    // announces a new preload word to the system clock side
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            upd_tgl_q <= 1'b0;
        end else if (pre_load || st_tlr) begin
            upd_tgl_q <= !upd_tgl_q;
        end
    end

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            id_sh_q <= bst_pkg::IDCODE_VAL;
        end else if (st_cap_dr && sel_id) begin
            id_sh_q <= bst_pkg::IDCODE_VAL; // [R3]
        end else if (st_sh_dr && sel_id) begin
            id_sh_q <= {tdi, id_sh_q[31:1]}; // [R3]
        end
    end

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            byp_q <= bst_pkg::BYP_CAPTURE;
        end else if (st_cap_dr && sel_byp) begin
            byp_q <= bst_pkg::BYP_CAPTURE; // [R11]
        end else if (st_sh_dr && sel_byp) begin
            byp_q <= tdi; // [R11]
        end
    end

    // ************************************************************
    // serial output, changed on the falling edge
    // ************************************************************
    wire dr_bit  = sel_bsr ? bsr_sh_q[0] :
                   sel_id  ? id_sh_q[0]  : byp_q;
    wire ser_out = st_sh_ir ? ir_sh_q[0] : dr_bit;
    wire ser_en  = st_sh_ir || st_sh_dr;

    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo    <= ser_out; // [R20]
            tdo_oe <= ser_en; // [R21]
        end
    end

    // ************************************************************
    // system clock side: output pad control
    // ************************************************************
    logic [2:0]       mode_s;
    logic             tgl_seen_q;
    logic [BSR_N-1:0] sys_pre_q;
    logic [QW-1:0]    pad_q_q;
    logic             pad_oe_q;

    bst_sync #(
        .W      (3)
    ) u_mode_sync (
        .clk    (sys_clk),
        .rst_n  (rst_n),
        .d      ({upd_tgl_q, ins_floatz, ins_extest}),
        .q      (mode_s)
    );

    wire ext_s   = mode_s[0];
    wire flt_s   = mode_s[1];
    wire tgl_s   = mode_s[2];
    // preload word is held until the next update, many cycles away
    wire pre_new = (tgl_s != tgl_seen_q);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_seen_q <= 1'b0;
            sys_pre_q  <= PRELOAD_RST;
        end else begin
            tgl_seen_q <= tgl_s;
            if (pre_new) begin
                sys_pre_q <= preload_q;
            end
        end
    end

    wire [QW-1:0] q_d  = ext_s ? sys_pre_q[Q_LSB +: QW] : core_q; // [R12]
    wire          tri_en = sys_pre_q[bst_pkg::TRI_CELL];
    wire          oe_d = flt_s ? 1'b0 :                       // [R5]
                         ext_s ? tri_en : core_q_oe;          // [R13]

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_q_q  <= '0;
            pad_oe_q <= 1'b0;
        end else begin
            pad_q_q  <= q_d;
            pad_oe_q <= oe_d;
        end
    end

    assign pad_q    = pad_q_q;
    assign pad_q_oe = pad_oe_q;

    // ************************************************************
    // checks
    // ************************************************************
    property p_five_high; // [R19]
        @(posedge tck) disable iff (!trst_n)
        tms [*5] |=> (state == bst_pkg::ST_TLR);
    endproperty
    a_five_high: assert property (p_five_high) // [R19]
        else $error("five tms highs did not reach reset state");

    property p_ir_update; // [R2]
        @(posedge tck) disable iff (!trst_n)
        st_upd_ir |=> (ir_q == $past(ir_sh_q));
    endproperty
    a_ir_update: assert property (p_ir_update) // [R2]
        else $error("instruction not applied at update");

    property p_ir_hold; // [R2]
        @(posedge tck) disable iff (!trst_n)
        (st_sh_ir && !st_tlr) ##1 st_sh_ir |-> $stable(ir_q);
    endproperty
    a_ir_hold: assert property (p_ir_hold) // [R2]
        else $error("instruction changed while shifting");

    property p_ir_reset; // [R4]
        @(posedge tck) disable iff (!trst_n)
        st_tlr |=> (ir_q == bst_pkg::INS_IDCODE);
    endproperty
    a_ir_reset: assert property (p_ir_reset) // [R4]
        else $error("reset state did not select identity");

    property p_ir_capture; // [R18]
        @(posedge tck) disable iff (!trst_n)
        st_cap_ir |=> (ir_sh_q[1:0] == 2'b01);
    endproperty
    a_ir_capture: assert property (p_ir_capture) // [R18]
        else $error("capture pattern missing in instruction");

    property p_id_capture; // [R3]
        @(posedge tck) disable iff (!trst_n)
        (st_cap_dr && sel_id) |=> (id_sh_q == bst_pkg::IDCODE_VAL);
    endproperty
    a_id_capture: assert property (p_id_capture) // [R3]
        else $error("identity value not captured");

    property p_byp_capture; // [R11]
        @(posedge tck) disable iff (!trst_n)
        (st_cap_dr && sel_byp) ##1 st_sh_dr |-> (byp_q == 1'b0);
    endproperty
    a_byp_capture: assert property (p_byp_capture) // [R11]
        else $error("bypass bit not cleared on capture");

    property p_bsr_shift; // [R10]
        @(posedge tck) disable iff (!trst_n)
        (st_sh_dr && sel_bsr) |=>
            (bsr_sh_q[BSR_N-1] == $past(tdi)) &&
            (bsr_sh_q[BSR_N-2:0] == $past(bsr_sh_q[BSR_N-1:1]));
    endproperty
    a_bsr_shift: assert property (p_bsr_shift) // [R10]
        else $error("scan chain did not shift toward data out");

    property p_preload; // [R9]
        @(posedge tck) disable iff (!trst_n)
        pre_load |=> (preload_q == $past(bsr_sh_q));
    endproperty
    a_preload: assert property (p_preload) // [R9]
        else $error("preload latches not updated");

    property p_tri_reset; // [R15]
        @(posedge tck) disable iff (!trst_n)
        st_tlr |=> preload_q[bst_pkg::TRI_CELL];
    endproperty
    a_tri_reset: assert property (p_tri_reset) // [R15]
        else $error("tri-state latch not set in reset state");

    // enable seen at a rising edge was set from the state then current
    property p_tdo_enable; // [R21]
        @(posedge tck) disable iff (!trst_n)
        tdo_oe == ((state == bst_pkg::ST_SH_IR) ||
                   (state == bst_pkg::ST_SH_DR));
    endproperty
    a_tdo_enable: assert property (p_tdo_enable) // [R21]
        else $error("data out enable outside shift states");

    property p_float; // [R5]
        @(posedge sys_clk) disable iff (!rst_n)
        flt_s |=> !pad_q_oe;
    endproperty
    a_float: assert property (p_float) // [R5]
        else $error("output bus driven under float mode");

    property p_tri_gate; // [R13]
        @(posedge sys_clk) disable iff (!rst_n)
        (ext_s && !flt_s) |=> (pad_q_oe == $past(tri_en));
    endproperty
    a_tri_gate: assert property (p_tri_gate) // [R13]
        else $error("tri-state cell did not gate outputs");

endmodule

/* File: sim/bst_jtag_ctl.sv */
`timescale 1ns/1ps
module bst_jtag_ctl (
    // test access port, controller side
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    logic tdo_s;
    logic oe_s;
    int   oe_bad;

    // ************************************************************
    // one test clock; tck rests low and tdi at pull-up between frames
    // ************************************************************
    initial begin
        tck    = 1'b0;
        tms    = 1'b1;
        tdi    = 1'b1;
        oe_bad = 0;
    end

    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        #6 tck = 1'b1;
        tdo_s = tdo;
        oe_s  = tdo_oe;
        #6 tck = 1'b0;
    endtask

    // five highs reach reset from any state, then park in idle
    task automatic tap_reset();
        repeat (5) step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask

    // idle to idle through one scan; ir selects the instruction column
    task automatic scan(input logic ir, input int n,
                        input logic [108:0] din,
                        output logic [108:0] dout);
        step(1'b1, 1'b1);
        if (ir) begin
            step(1'b1, 1'b1);
        end
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i]);
            dout[i] = tdo_s;
            if (oe_s !== 1'b1) begin
                oe_bad++;
            end
        end
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
endmodule

/* File: sim/test_boundary_scan_tap_instructions.sv */
`timescale 1ns/1ps
module test_boundary_scan_tap_instructions;
    localparam int N  = bst_pkg::BSR_LEN;
    localparam int QW = bst_pkg::Q_W;
    localparam int TC = bst_pkg::TRI_CELL;

    logic          sys_clk;
    logic          rst_n;
    logic          tck;
    logic          tms;
    logic          tdi;
    logic          tdo;
    logic          tdo_oe;
    logic [N-1:0]  pins;
    logic [QW-1:0] core_q;
    logic          core_q_oe;
    logic [QW-1:0] pad_q;
    logic          pad_q_oe;
    logic [N-1:0]  got;
    logic [N-1:0]  pat;
    logic [N-1:0]  pl;
    integer        seed;
    int            bad_count;
    int            n_tests;

    bst_top u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .bsr_pin_lvl(pins),
        .core_q(core_q), .core_q_oe(core_q_oe), .pad_q(pad_q),
        .pad_q_oe(pad_q_oe)
    );

    bst_jtag_ctl u_ctl (
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ************************************************************
    // checking and expectations
    // ************************************************************
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_scan(input logic [N-1:0] g, input logic [N-1:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_pad(input logic [QW:0] g, input logic [QW:0] e);
        chk_scan(N'(g), N'(e));
    endtask

    function automatic logic [N-1:0] rnd();
        return N'({$random(seed), $random(seed), $random(seed),
                   $random(seed)});
    endfunction

    // bypass cell captures 0 and delays the stream by one bit
    function automatic logic [N-1:0] exp_byp(input logic [N-1:0] d,
                                             input int n);
        return (d << 1) & ((N'(1) << n) - N'(1));
    endfunction

    function automatic logic [QW:0] exp_pad(input logic [2:0] ins);
        if (ins == bst_pkg::INS_SAMPLEZ) begin
            return '0;
        end
        if (ins == bst_pkg::INS_EXTEST) begin
            return pl[TC] ? {1'b1, pl[QW-1:0]} : '0;
        end
        return core_q_oe ? {1'b1, core_q} : '0;
    endfunction

    // pad data is only meaningful while the drivers are enabled
    task automatic pad_check(input logic [2:0] ins);
        logic [QW:0] e;
        repeat (10) @(negedge sys_clk);
        e = exp_pad(ins);
        chk_pad({pad_q_oe, e[QW] ? pad_q : {QW{1'b0}}}, e);
    endtask

    // only implemented codes are ever loaded: EXTEST, SAMPLE, SAMPLE Z and BYPASS; IDCODE comes from reset
    task automatic ir(input logic [2:0] code);
        u_ctl.scan(1'b1, 3, N'(code), got);
        chk_scan(got, N'(bst_pkg::IR_CAPTURE));
        chk_scan(N'(tdo_oe), '0);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        seed      = 48099;
        bad_count = 0;
        n_tests   = 0;
        rst_n     = 1'b0;
        pins      = '0;
        core_q    = '0;
        core_q_oe = 1'b0;
        pl        = '0;
        pl[TC]    = bst_pkg::TRI_RESET;
        // the test clock must tick while reset is low
        fork
            repeat (10) @(negedge sys_clk);
            u_ctl.tap_reset();
        join
        @(negedge sys_clk);
        rst_n = 1'b1;
        u_ctl.tap_reset();
        for (int r = 0; r < 4; r++) begin
            @(negedge sys_clk);
            core_q    = QW'(rnd());
            core_q_oe = (r != 2);
            pins      = rnd(); // held still over each capture
            u_ctl.scan(1'b0, 32, rnd(), got);
            chk_scan(got, N'(bst_pkg::IDCODE_VAL));
            ir(bst_pkg::INS_EXTEST);
            pad_check(bst_pkg::INS_EXTEST);
            ir(bst_pkg::INS_SAMPLE);
            pad_check(bst_pkg::INS_SAMPLE);
            pat     = rnd();
            pat[TC] = r[0];
            u_ctl.scan(1'b0, N, pat, got);
            chk_scan(got, pins);
            pl = pat;
            ir(bst_pkg::INS_EXTEST);
            pad_check(bst_pkg::INS_EXTEST);
            @(negedge sys_clk);
            pins    = rnd();
            pat     = rnd();
            pat[TC] = ~r[0];
            u_ctl.scan(1'b0, N, pat, got);
            chk_scan(got, pins);
            pl = pat;
            pad_check(bst_pkg::INS_EXTEST);
            ir(bst_pkg::INS_SAMPLEZ);
            pad_check(bst_pkg::INS_SAMPLEZ);
            u_ctl.scan(1'b0, N, rnd(), got);
            chk_scan(got, pins);
            ir(bst_pkg::INS_BYPASS);
            pad_check(bst_pkg::INS_BYPASS);
            pat = rnd();
            u_ctl.scan(1'b0, 8 + r, pat, got);
            chk_scan(got, exp_byp(pat, 8 + r));
            u_ctl.tap_reset();
            pl[TC] = bst_pkg::TRI_RESET;
        end
        chk_scan(N'(u_ctl.oe_bad), '0);
        end_of_test();
    end

    // a hung run is cut short and reported
    initial begin
        #400000;
        bad_count++;
        end_of_test();
    end
endmodule
